// ### fea_pkg.sv
// Purpose: Shared constants for the frequency error autotrim block
// Assumes: 32-bit register port, byte addresses in steps of four
// Notes:   Register offsets, field layout and reset values
`default_nettype none
package fea_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int ERR_W  = 16;
  localparam int STEP_W = 8;
  localparam int ADJ_W  = 6;
  localparam int STS_W  = 5;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CFG    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_ADJ    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h10;

  // Control field
  localparam int CTRL_AUTO_BIT = 0;

  // Status and mask field positions
  localparam int STS_GOOD = 0;
  localparam int STS_WARN = 1;
  localparam int STS_ERR  = 2;
  localparam int STS_MISS = 3;
  localparam int STS_OVF  = 4;

  // Reset values and trim limits
  localparam logic [STEP_W-1:0] STEP_RST = 8'h22;
  localparam logic [ADJ_W-1:0]  ADJ_RST  = 6'h20;
  localparam logic [ADJ_W-1:0]  ADJ_MAX  = 6'h3f;
  localparam logic [ADJ_W-1:0]  ADJ_MIN  = 6'h00;

  // Limit multipliers
  localparam int WARN_MULT = 3;
  localparam int OUTR_MULT = 128;

  // Adjust step sizes
  localparam logic [1:0] STEP_NONE = 2'h0;
  localparam logic [1:0] STEP_ONE  = 2'h1;
  localparam logic [1:0] STEP_TWO  = 2'h2;

  typedef enum logic [1:0] {
    CLS_GOOD,
    CLS_NEAR,
    CLS_WARN,
    CLS_ERR
  } fea_class_t;
endpackage
`default_nettype wire

// ### fea_sat_adj.sv
// Purpose: Saturating up/down adjust of the oscillator trim value
// Assumes: Step of zero, one or two units
// Notes:   Flags overflow when the result is clamped
`timescale 1ns/1ps
`default_nettype none
module fea_sat_adj (
  // Operand
  input  wire logic [fea_pkg::ADJ_W-1:0] value,
  input  wire logic [1:0]                step,
  input  wire logic                      up,
  // Result
  output logic      [fea_pkg::ADJ_W-1:0] result,
  output logic                           clamped
);
  logic [fea_pkg::ADJ_W:0] sum_up;
  logic [fea_pkg::ADJ_W:0] sum_dn;
  logic                    ovf_up;
  logic                    ovf_dn;

  assign sum_up = {1'b0, value} + {{(fea_pkg::ADJ_W-1){1'b0}}, step};
  assign sum_dn = {1'b0, value} - {{(fea_pkg::ADJ_W-1){1'b0}}, step};
  assign ovf_up = sum_up[fea_pkg::ADJ_W];
  assign ovf_dn = sum_dn[fea_pkg::ADJ_W];

  assign result  = up ? (ovf_up ? fea_pkg::ADJ_MAX
                                : sum_up[fea_pkg::ADJ_W-1:0])
                      : (ovf_dn ? fea_pkg::ADJ_MIN
                                : sum_dn[fea_pkg::ADJ_W-1:0]);
  assign clamped = up ? ovf_up : ovf_dn;
endmodule
`default_nettype wire

// ### fea_autotrim.sv
// Purpose: Frequency error classification and automatic trim
// Assumes: Error magnitude and direction valid with the sync pulse
// Notes:   Register port with read data one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module fea_autotrim (
  // Clock and reset
  input  wire logic                        MCLK,
  input  wire logic                        RSTN,
  // Register port
  input  wire logic [fea_pkg::ADDR_W-1:0]  ADDR,
  input  wire logic [fea_pkg::DATA_W-1:0]  WDATA,
  input  wire logic                        WR,
  input  wire logic                        RD,
  output logic      [fea_pkg::DATA_W-1:0]  RDATA,
  // Measurement inputs
  input  wire logic                        SYNC_EVT,
  input  wire logic                        SYNC_LOST,
  input  wire logic [fea_pkg::ERR_W-1:0]   ERR_MAG,
  input  wire logic                        ERR_FAST,
  // Outputs
  output logic      [fea_pkg::ADJ_W-1:0]   TRIM,
  output logic                             IRQ
);
  logic                        auto_adjust_enable_reg;
  logic [fea_pkg::STEP_W-1:0]  error_limit_step_reg;
  logic [fea_pkg::ADJ_W-1:0]   adj_reg;
  logic [fea_pkg::ADJ_W-1:0]   adj_next;
  logic [fea_pkg::STS_W-1:0]   status_reg;
  logic [fea_pkg::STS_W-1:0]   status_next;
  logic [fea_pkg::STS_W-1:0]   mask_reg;
  logic [fea_pkg::DATA_W-1:0]  rdata_reg;
  logic [fea_pkg::DATA_W-1:0]  rdata_next;

  logic [fea_pkg::ERR_W-1:0]   tol_lim;
  logic [fea_pkg::ERR_W-1:0]   warn_lim;
  logic [fea_pkg::ERR_W-1:0]   outr_lim;
  fea_pkg::fea_class_t         cls;
  logic [1:0]                  step_sel;
  logic [fea_pkg::ADJ_W-1:0]   adj_hw;
  logic                        adj_clamped;
  logic                        hw_update;
  logic [fea_pkg::STS_W-1:0]   sts_set;
  logic [fea_pkg::STS_W-1:0]   sts_clr;

  logic wr_ctrl;
  logic wr_cfg;
  logic wr_adj;
  logic wr_status;
  logic wr_mask;
  logic sync_good_flag;
  logic sync_warning_flag;
  logic sync_error_flag;
  logic sync_missing_flag;
  logic adjust_overflow_flag;

  // Limits
  assign tol_lim  = {{(fea_pkg::ERR_W-fea_pkg::STEP_W){1'b0}},
                     error_limit_step_reg};
  assign warn_lim = 16'(fea_pkg::WARN_MULT * tol_lim);
  assign outr_lim = 16'(fea_pkg::OUTR_MULT * tol_lim);

  // Classification
  always_comb begin
    if (ERR_MAG < tol_lim) begin
      cls = fea_pkg::CLS_GOOD;
    end else if (ERR_MAG < warn_lim) begin
      cls = fea_pkg::CLS_NEAR;
    end else if (ERR_MAG < outr_lim) begin
      cls = fea_pkg::CLS_WARN;
    end else begin
      cls = fea_pkg::CLS_ERR;
    end
  end

  always_comb begin
    case (cls)
      fea_pkg::CLS_GOOD: step_sel = fea_pkg::STEP_NONE;
      fea_pkg::CLS_NEAR: step_sel = fea_pkg::STEP_ONE;
      fea_pkg::CLS_WARN: step_sel = fea_pkg::STEP_TWO;
      fea_pkg::CLS_ERR:  step_sel = fea_pkg::STEP_NONE;
      default:           step_sel = fea_pkg::STEP_NONE;
    endcase
  end

  // Saturating adjust
  fea_sat_adj u_sat (
    .value   (adj_reg),
    .step    (step_sel),
    .up      (~ERR_FAST),
    .result  (adj_hw),
    .clamped (adj_clamped)
  );

  // Evaluation strobes
  assign hw_update = SYNC_EVT & ~SYNC_LOST & auto_adjust_enable_reg;
  assign sync_good_flag    = SYNC_EVT & ~SYNC_LOST &
                             ((cls == fea_pkg::CLS_GOOD) |
                              (cls == fea_pkg::CLS_NEAR));
  assign sync_warning_flag = SYNC_EVT & ~SYNC_LOST &
                             (cls == fea_pkg::CLS_WARN);
  assign sync_error_flag   = SYNC_EVT & ~SYNC_LOST &
                             (cls == fea_pkg::CLS_ERR);
  assign sync_missing_flag = SYNC_LOST;
  assign adjust_overflow_flag = hw_update & adj_clamped &
                                (step_sel != fea_pkg::STEP_NONE);

  // Register decode
  assign wr_ctrl   = WR & (ADDR == fea_pkg::OFS_CTRL);
  assign wr_cfg    = WR & (ADDR == fea_pkg::OFS_CFG);
  assign wr_adj    = WR & (ADDR == fea_pkg::OFS_ADJ);
  assign wr_status = WR & (ADDR == fea_pkg::OFS_STATUS);
  assign wr_mask   = WR & (ADDR == fea_pkg::OFS_MASK);

  // Trim next value
  assign adj_next = hw_update ? adj_hw :
                    (wr_adj & ~auto_adjust_enable_reg) ?
                    WDATA[fea_pkg::ADJ_W-1:0] : adj_reg;

  // Status set wins over clear
  always_comb begin
    sts_set = '0;
    sts_set[fea_pkg::STS_GOOD] = sync_good_flag;
    sts_set[fea_pkg::STS_WARN] = sync_warning_flag;
    sts_set[fea_pkg::STS_ERR]  = sync_error_flag;
    sts_set[fea_pkg::STS_MISS] = sync_missing_flag;
    sts_set[fea_pkg::STS_OVF]  = adjust_overflow_flag;
  end
  assign sts_clr     = wr_status ? WDATA[fea_pkg::STS_W-1:0] : '0;
  assign status_next = (status_reg & ~sts_clr) | sts_set;

  // Read mux
  always_comb begin
    rdata_next = '0;
    if (RD) begin
      case (ADDR)
        fea_pkg::OFS_CTRL:
          rdata_next[fea_pkg::CTRL_AUTO_BIT] = auto_adjust_enable_reg;
        fea_pkg::OFS_CFG:
          rdata_next[fea_pkg::STEP_W-1:0] = error_limit_step_reg;
        fea_pkg::OFS_ADJ:
          rdata_next[fea_pkg::ADJ_W-1:0] = adj_reg;
        fea_pkg::OFS_STATUS:
          rdata_next[fea_pkg::STS_W-1:0] = status_reg;
        fea_pkg::OFS_MASK:
          rdata_next[fea_pkg::STS_W-1:0] = mask_reg;
        default:
          rdata_next = '0;
      endcase
    end
  end

  // Control registers
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      auto_adjust_enable_reg <= 1'b0;
      error_limit_step_reg   <= fea_pkg::STEP_RST;
      mask_reg               <= '0;
    end else begin
      if (wr_ctrl) begin
        auto_adjust_enable_reg <= WDATA[fea_pkg::CTRL_AUTO_BIT];
      end
      if (wr_cfg) begin
        error_limit_step_reg <= WDATA[fea_pkg::STEP_W-1:0];
      end
      if (wr_mask) begin
        mask_reg <= WDATA[fea_pkg::STS_W-1:0];
      end
    end
  end

  // State registers
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      adj_reg    <= fea_pkg::ADJ_RST;
      status_reg <= '0;
      rdata_reg  <= '0;
    end else begin
      adj_reg    <= adj_next;
      status_reg <= status_next;
      rdata_reg  <= rdata_next;
    end
  end

  assign RDATA = rdata_reg;
  assign TRIM  = adj_reg;
  assign IRQ   = |(status_reg & mask_reg);
endmodule
`default_nettype wire

// ### fea_sync_src.sv
// Purpose: Reference sync pulse source
// Assumes: One event per send call
// Notes:   Measurement lines scrambled between events
`timescale 1ns/1ps
`default_nettype none
module fea_sync_src #(
  parameter int GAP = 2
) (
  // Clock
  input  wire logic        clk,
  // Measurement
  output logic             evt,
  output logic             lost,
  output logic      [15:0] mag,
  output logic             fast
);
  initial begin
    evt = 1'b0;
    lost = 1'b0;
    mag = 16'h0000;
    fast = 1'b0;
  end
  task automatic send(input logic [15:0] m, input logic f, input logic l);
    repeat (GAP) @(posedge clk);
    evt <= !l;
    lost <= l;
    mag <= m;
    fast <= f;
    @(posedge clk);
    evt <= 1'b0;
    lost <= 1'b0;
    mag <= ~m;
    fast <= ~f;
  endtask
endmodule
`default_nettype wire

// ### fea_autotrim_sva.sv
// Purpose: Port checker for the autotrim block
// Assumes: Step and auto enable tracked from port writes
// Notes:   Bound at the foot
`timescale 1ns/1ps
`default_nettype none
module fea_autotrim_sva (
  // Clock and reset
  input wire logic        MCLK,
  input wire logic        RSTN,
  // Register port
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  // Measurement and outputs
  input wire logic        SYNC_EVT,
  input wire logic        SYNC_LOST,
  input wire logic [15:0] ERR_MAG,
  input wire logic        ERR_FAST,
  input wire logic [5:0]  TRIM,
  input wire logic        IRQ
);
  logic [7:0]  step_reg;
  logic        auto_reg;
  logic [15:0] l1, l3, l7;
  logic        ev, nw, qt;
  logic [1:0]  d;
  int          r;
  logic [5:0]  ex;
  assign l1 = {8'h00, step_reg};
  assign l3 = l1 * 16'h0003;
  assign l7 = l1 * 16'h0080;
  assign ev = SYNC_EVT && !SYNC_LOST;
  assign nw = !(WR && ADDR == fea_pkg::OFS_ADJ);
  assign qt = !SYNC_EVT && !SYNC_LOST;
  assign d = ERR_MAG < l1 ? 2'h0 : ERR_MAG < l3 ? 2'h1 :
             ERR_MAG < l7 ? 2'h2 : 2'h0;
  always_comb begin
    r = ERR_FAST ? int'(TRIM) - int'(d) : int'(TRIM) + int'(d);
    ex = r > 63 ? 6'h3f : r < 0 ? 6'h00 : 6'(r);
  end
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      step_reg <= fea_pkg::STEP_RST;
      auto_reg <= 1'b0;
    end else if (WR && ADDR == fea_pkg::OFS_CFG) begin
      step_reg <= WDATA[7:0];
    end else if (WR && ADDR == fea_pkg::OFS_CTRL) begin
      auto_reg <= WDATA[0];
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  a_good_hold: assert property (
    ev && ERR_MAG < l1 && nw |=> $stable(TRIM)) else $error("good moved");
  a_near_one: assert property (
    auto_reg && ev && d == 2'h1 |=> TRIM == $past(ex)) else $error("one");
  a_warn_two: assert property (
    auto_reg && ev && d == 2'h2 |=> TRIM == $past(ex)) else $error("two");
  a_err_hold: assert property (
    (SYNC_LOST || ev && ERR_MAG >= l7) && nw |=> $stable(TRIM))
    else $error("error moved");
  a_manual_hold: assert property (
    !auto_reg && !qt && nw |=> $stable(TRIM)) else $error("manual moved");
  a_sw_ignored: assert property (
    auto_reg && !nw && qt |=> $stable(TRIM)) else $error("write taken");
  a_sw_write: assert property (
    !auto_reg && !nw && qt |=> TRIM == $past(WDATA[5:0]))
    else $error("write lost");
  a_quiet_hold: assert property (
    qt && nw |=> $stable(TRIM)) else $error("trim moved idle");
  a_read_once: assert property (
    !RD |=> RDATA == 32'h0) else $error("read data stands");
  c_warn: cover property (auto_reg && ev && d == 2'h2);
  c_lost: cover property (SYNC_LOST);
  c_clamp: cover property (auto_reg && ev && d != 2'h0 && TRIM == 6'h3f);
endmodule
bind fea_autotrim fea_autotrim_sva u_fea_autotrim_sva (
  .MCLK(MCLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .RDATA(RDATA), .SYNC_EVT(SYNC_EVT), .SYNC_LOST(SYNC_LOST),
  .ERR_MAG(ERR_MAG), .ERR_FAST(ERR_FAST), .TRIM(TRIM), .IRQ(IRQ));
`default_nettype wire

// ### fea_autotrim_tb.sv
// Purpose: Self-checking bench for the autotrim block
// Assumes: Random events with limit corner values
// Notes:   Expected trim and status kept by the bench
`timescale 1ns/1ps
`default_nettype none
module fea_autotrim_tb;
  logic MCLK, RSTN, WR, RD, SYNC_EVT, SYNC_LOST, ERR_FAST, IRQ, ma, f, l;
  logic [7:0] ADDR, ms;
  logic [31:0] WDATA, RDATA;
  logic [15:0] ERR_MAG, m, lim;
  logic [5:0] TRIM, mt, t;
  logic [4:0] sts, msk, b;
  int mismatches, checks, k;
  fea_autotrim u_fea_autotrim (.MCLK(MCLK), .RSTN(RSTN), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SYNC_EVT(SYNC_EVT),
    .SYNC_LOST(SYNC_LOST), .ERR_MAG(ERR_MAG), .ERR_FAST(ERR_FAST),
    .TRIM(TRIM), .IRQ(IRQ));
  fea_sync_src u_fea_sync_src (.clk(MCLK), .evt(SYNC_EVT),
    .lost(SYNC_LOST), .mag(ERR_MAG), .fast(ERR_FAST));
  initial begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge MCLK);
    WR <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge MCLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge MCLK);
    RD <= 1'b0;
    #1;
    chk(RDATA, e);
  endtask
  function automatic logic [5:0] nx(input logic [5:0] v, output logic [4:0] o);
    logic [15:0] l3, l7;
    int d, r;
    l3 = lim * 16'h0003;
    l7 = lim * 16'h0080;
    d = m < lim ? 0 : m < l3 ? 1 : m < l7 ? 2 : 0;
    o = m < l3 ? 5'h01 : m < l7 ? 5'h02 : 5'h04;
    d = ma ? d : 0;
    r = f ? int'(v) - d : int'(v) + d;
    if (r > 63 || r < 0) o = o | 5'h10;
    return r > 63 ? 6'h3f : r < 0 ? 6'h00 : 6'(r);
  endfunction
  task automatic results;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge MCLK);
    mismatches++;
    results();
  end
  initial begin
    {RSTN, WR, RD, ADDR, WDATA} = '0;
    void'($urandom(32'h21960ef1));
    repeat (4) @(posedge MCLK);
    RSTN <= 1'b1;
    #1;
    chk({26'h0, TRIM}, {26'h0, fea_pkg::ADJ_RST});
    rd(fea_pkg::OFS_CTRL, 32'h0);
    rd(fea_pkg::OFS_CFG, {24'h0, fea_pkg::STEP_RST});
    rd(fea_pkg::OFS_ADJ, {26'h0, fea_pkg::ADJ_RST});
    rd(fea_pkg::OFS_STATUS, 32'h0);
    rd(fea_pkg::OFS_MASK, 32'h0);
    wr(8'h14, 32'hffffffff);
    rd(8'h14, 32'h0);
    {mt, sts} = {fea_pkg::ADJ_RST, 5'h00};
    for (int i = 0; i < 200; i++) begin
      if (i % 8 == 0) begin
        ma = 1'($urandom);
        wr(fea_pkg::OFS_CTRL, {31'h0, ma});
        rd(fea_pkg::OFS_CTRL, {31'h0, ma});
        b = 5'($urandom);
        t = b[0] ? {6{b[1]}} : 6'($urandom);
        wr(fea_pkg::OFS_ADJ, {26'h0, t});
        mt = ma ? mt : t;
        chk({26'h0, TRIM}, {26'h0, mt});
        rd(fea_pkg::OFS_ADJ, {26'h0, mt});
        ms = 8'($urandom);
        lim = {8'h00, ms};
        wr(fea_pkg::OFS_CFG, {24'h0, ms});
        rd(fea_pkg::OFS_CFG, {24'h0, ms});
        msk = 5'($urandom);
        wr(fea_pkg::OFS_MASK, {27'h0, msk});
        rd(fea_pkg::OFS_MASK, {27'h0, msk});
      end
      f = 1'($urandom);
      l = ($urandom % 16) == 0;
      k = $urandom % 8;
      m = 16'(k == 0 ? lim - 1 : k == 1 ? lim : k == 2 ? lim * 3 - 1 :
          k == 3 ? lim * 3 : k == 4 ? lim * 128 - 1 : k == 5 ? lim * 128 :
          $urandom % (int'(lim) * 130 + 1));
      u_fea_sync_src.send(m, f, l);
      #1;
      b = 5'h08;
      if (!l) mt = nx(mt, b);
      sts = sts | b;
      chk({26'h0, TRIM}, {26'h0, mt});
      chk({31'h0, IRQ}, {31'h0, |(sts & msk)});
      if (i % 2 == 0) begin
        rd(fea_pkg::OFS_STATUS, {27'h0, sts});
        wr(fea_pkg::OFS_STATUS, {27'h0, sts});
        sts = 5'h00;
      end
    end
    results();
  end
endmodule
`default_nettype wire
